// ---- legacy_route_pkg.sv ----
// Package for the legacy route and remap decode block.
// Assumes a single-clock hub core with byte-addressed config space.
package legacy_route_pkg;

  // ---------------------------------------------------------------
  // Config register offsets, widths and resets
  // ---------------------------------------------------------------
  localparam logic [7:0] REMAP_LOW_OFS = 8'h98;
  localparam logic [7:0] REMAP_HIGH_OFS = 8'h9a;
  localparam int BOUND_W = 10;
  localparam int BOUND_LSB = 0;
  localparam logic [15:0] REMAP_LOW_RST = 16'h03ff;
  localparam logic [15:0] REMAP_HIGH_RST = 16'h0000;
  localparam int ADDR_W = 36;
  localparam int WIN_LSB = 26;

  // ---------------------------------------------------------------
  // Mono adapter and VGA ranges
  // ---------------------------------------------------------------
  localparam logic [19:0] MONO_MEM_LO = 20'hb0000;
  localparam logic [19:0] MONO_MEM_HI = 20'hb7fff;
  localparam logic [9:0] MONO_IO_A = 10'h3b4;
  localparam logic [9:0] MONO_IO_B = 10'h3b5;
  localparam logic [9:0] MONO_IO_C_LO = 10'h3b8;
  localparam logic [9:0] MONO_IO_C_HI = 10'h3bf;
  localparam logic [9:0] VGA_IO_LO = 10'h3c0;
  localparam logic [9:0] VGA_IO_HI = 10'h3df;
  localparam logic [19:0] VGA_MEM_LO = 20'ha0000;
  localparam logic [19:0] VGA_MEM_HI = 20'hbffff;

  // Route target
  typedef enum logic {
    DEST_SOUTH_LINK,
    DEST_GFX_PORT
  } dest_t;

  // Incoming host cycle
  typedef struct packed {
    logic valid;
    logic is_io;
    logic [ADDR_W-1:0] addr;
    logic [3:0] byte_en;
  } host_cyc_t;

  // Decode result
  typedef struct packed {
    logic valid;
    logic legacy_hit;
    dest_t dest;
    logic remap_hit;
  } route_res_t;

  // Config write/read port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] ofs;
    logic [15:0] wdata;
  } cfg_req_t;

endpackage : legacy_route_pkg

// ---- legacy_route_remap_decode.sv ----
// Overview of operation
// - Mono mem B0000-B7FFF; I/O 3B4, 3B5, 3B8-3BF; bits 15:10 ignored.
// - Mono-present and VGA enable together choose where mono cycles go; here mono cycles go to south link in every setting.
// - I/O cycle touching any mono port or alias goes to south link.
// - Both bits 0: all mono and VGA references go to south link.
// - Both bits 1: mono references go to south link.
// - Low bound is 10 bits in 9:0, address 35:26, inclusive.
// - Low bound compared with address 25:0 as zeros.
// - Window disabled when low bound exceeds high bound.
// - High bound is 10 bits in 9:0, address 35:26, inclusive.
// - High bound compared with address 25:0 as ones.
// - Window disabled when high bound below low bound.
// - Low bound resets to 3FFh, window starts disabled.
// - High bound resets to zero.
//
// Top of the legacy route / remap decoder; one decode per cycle.
// Assumes the host side presents one cycle per clock, no back-pressure.
`timescale 1ns/1ps

module legacy_route_remap_decode (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic vga_route_enable,
  input wire logic mono_adapter_present,
  input wire legacy_route_pkg::cfg_req_t cfg_req,
  input wire legacy_route_pkg::host_cyc_t host_cyc,
  output logic [15:0] cfg_rdata,
  output logic cfg_rvalid,
  output legacy_route_pkg::route_res_t route_res,
  output logic remap_win_enabled
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [legacy_route_pkg::BOUND_W-1:0] low_bound;
    logic [legacy_route_pkg::BOUND_W-1:0] high_bound;
    logic [15:0] rdata;
    logic rvalid;
    legacy_route_pkg::route_res_t res;
    logic win_en;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ---------------------------------------------------------------
  // Combinational decode
  // ---------------------------------------------------------------
  logic [9:0] io_low10;
  logic [3:0] io_port_hit;
  logic mono_io;
  logic mono_mem;
  logic vga_space;
  logic win_on;
  logic [legacy_route_pkg::BOUND_W-1:0] addr_hi;
  logic [35:0] win_base;
  logic [35:0] win_top;

  // Byte lanes of an I/O cycle; aliases drop address bits 15:10
  assign io_low10 = {host_cyc.addr[9:2], 2'b00};

  // One compare per enabled byte lane
  for (genvar i = 0; i < 4; i++) begin : g_lane
    logic [9:0] port;
    assign port = io_low10 | 10'(i);
    assign io_port_hit[i] = host_cyc.byte_en[i] &&
      (port == legacy_route_pkg::MONO_IO_A ||
       port == legacy_route_pkg::MONO_IO_B ||
       (port >= legacy_route_pkg::MONO_IO_C_LO &&
        port <= legacy_route_pkg::MONO_IO_C_HI));
  end

  // Any touched mono lane claims the whole cycle
  assign mono_io = host_cyc.is_io && (|io_port_hit);

  assign mono_mem = !host_cyc.is_io &&
    host_cyc.addr[35:20] == 16'h0000 &&
    host_cyc.addr[19:0] >= legacy_route_pkg::MONO_MEM_LO &&
    host_cyc.addr[19:0] <= legacy_route_pkg::MONO_MEM_HI;

  // VGA window, used to flag and steer legacy graphics references
  assign vga_space = host_cyc.is_io ?
    (host_cyc.addr[9:0] >= legacy_route_pkg::VGA_IO_LO &&
     host_cyc.addr[9:0] <= legacy_route_pkg::VGA_IO_HI) :
    (host_cyc.addr[35:20] == 16'h0000 &&
     host_cyc.addr[19:0] >= legacy_route_pkg::VGA_MEM_LO &&
     host_cyc.addr[19:0] <= legacy_route_pkg::VGA_MEM_HI);

  // Full-width bounds: low pads zeros, high pads ones
  assign win_base = {s_q.low_bound, 26'h0000000};
  assign win_top = {s_q.high_bound, 26'h3ffffff};
  assign addr_hi = host_cyc.addr[35:26];

  // Crossed bounds close the window
  assign win_on = !(s_q.low_bound > s_q.high_bound);

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.win_en = win_on;
    // Config writes take the low ten bits; reserved bits stay zero
    if (cfg_req.wr) begin
      if (cfg_req.ofs == legacy_route_pkg::REMAP_LOW_OFS) begin
        s_d.low_bound = cfg_req.wdata[legacy_route_pkg::BOUND_W-1:0];
      end
      if (cfg_req.ofs == legacy_route_pkg::REMAP_HIGH_OFS) begin
        s_d.high_bound = cfg_req.wdata[legacy_route_pkg::BOUND_W-1:0];
      end
    end
    // Reads show stored bounds; unmapped offsets read zero
    if (cfg_req.rd) begin
      s_d.rvalid = 1'b1;
      case (cfg_req.ofs)
        legacy_route_pkg::REMAP_LOW_OFS: s_d.rdata = {6'h00, s_q.low_bound};
        legacy_route_pkg::REMAP_HIGH_OFS:
          s_d.rdata = {6'h00, s_q.high_bound};
        default: s_d.rdata = 16'h0000;
      endcase
    end
    // Route decode; mixed settings (undefined) send VGA space outside mono memory to graphics port
    s_d.res.valid = host_cyc.valid;
    s_d.res.legacy_hit = host_cyc.valid && (mono_io || mono_mem || vga_space);
    s_d.res.dest = legacy_route_pkg::DEST_SOUTH_LINK;
    if (mono_io) begin
      s_d.res.dest = legacy_route_pkg::DEST_SOUTH_LINK;
    end else if (!vga_route_enable && !mono_adapter_present) begin
      s_d.res.dest = legacy_route_pkg::DEST_SOUTH_LINK;
    end else if (vga_route_enable && mono_adapter_present) begin
      // Mono to south link, VGA to graphics port
      s_d.res.dest = (mono_mem) ? legacy_route_pkg::DEST_SOUTH_LINK :
        (vga_space ? legacy_route_pkg::DEST_GFX_PORT :
         legacy_route_pkg::DEST_SOUTH_LINK);
    end else if (vga_space && !mono_mem) begin
      s_d.res.dest = legacy_route_pkg::DEST_GFX_PORT;
    end
    s_d.res.remap_hit = host_cyc.valid && !host_cyc.is_io && win_on &&
      addr_hi >= s_q.low_bound && addr_hi <= s_q.high_bound;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.low_bound <= legacy_route_pkg::REMAP_LOW_RST[9:0];
      s_q.high_bound <= legacy_route_pkg::REMAP_HIGH_RST[9:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg_rdata = s_q.rdata;
  assign cfg_rvalid = s_q.rvalid;
  assign route_res = s_q.res;
  assign remap_win_enabled = s_q.win_en;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_mono_io_south;
    @(posedge sys_clk) disable iff (rst)
    (host_cyc.valid && mono_io) |=>
      route_res.dest == legacy_route_pkg::DEST_SOUTH_LINK;
  endproperty
  a_mono_io_south: assert property (p_mono_io_south)
    else $error("mono I/O cycle not sent to south link");

  property p_both_off_south;
    @(posedge sys_clk) disable iff (rst)
    (host_cyc.valid && !vga_route_enable && !mono_adapter_present) |=>
      route_res.dest == legacy_route_pkg::DEST_SOUTH_LINK;
  endproperty
  a_both_off_south: assert property (p_both_off_south)
    else $error("legacy cycle left south link with both bits clear");

  property p_both_on_mono;
    @(posedge sys_clk) disable iff (rst)
    (host_cyc.valid && vga_route_enable && mono_adapter_present &&
     mono_mem) |=> route_res.dest == legacy_route_pkg::DEST_SOUTH_LINK;
  endproperty
  a_both_on_mono: assert property (p_both_on_mono)
    else $error("mono memory not on south link");

  property p_vga_gfx;
    @(posedge sys_clk) disable iff (rst)
    (host_cyc.valid && vga_route_enable && mono_adapter_present &&
     vga_space && !mono_mem && !mono_io) |=>
      route_res.dest == legacy_route_pkg::DEST_GFX_PORT;
  endproperty
  a_vga_gfx: assert property (p_vga_gfx)
    else $error("VGA cycle not on graphics port");

  property p_reset_bounds;
    @(posedge sys_clk) $past(rst) |->
      s_q.low_bound == 10'h3ff && s_q.high_bound == 10'h000 && !win_on;
  endproperty
  a_reset_bounds: assert property (p_reset_bounds)
    else $error("bounds wrong after reset");

  property p_high_reset;
    @(posedge sys_clk) (rst ##1 !rst && !cfg_req.wr) |=>
      s_q.high_bound == 10'h000;
  endproperty
  a_high_reset: assert property (p_high_reset)
    else $error("high bound not zero after reset");

  property p_low_write;
    @(posedge sys_clk) disable iff (rst)
    (cfg_req.wr && cfg_req.ofs == legacy_route_pkg::REMAP_LOW_OFS) |=>
      s_q.low_bound == $past(cfg_req.wdata[9:0]);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("low bound write lost");

  property p_high_write;
    @(posedge sys_clk) disable iff (rst)
    (cfg_req.wr && cfg_req.ofs == legacy_route_pkg::REMAP_HIGH_OFS) |=>
      s_q.high_bound == $past(cfg_req.wdata[9:0]);
  endproperty
  a_high_write: assert property (p_high_write)
    else $error("high bound write lost");

  property p_crossed_no_hit;
    @(posedge sys_clk) disable iff (rst)
    (s_q.low_bound > s_q.high_bound) |=> !route_res.remap_hit;
  endproperty
  a_crossed_no_hit: assert property (p_crossed_no_hit)
    else $error("remap hit while bounds crossed");

  property p_edges_hit;
    @(posedge sys_clk) disable iff (rst)
    (host_cyc.valid && !host_cyc.is_io && win_on &&
     (host_cyc.addr == win_base || host_cyc.addr == win_top)) |=>
      route_res.remap_hit;
  endproperty
  a_edges_hit: assert property (p_edges_hit)
    else $error("window edge address missed");

  property p_hit_in_range;
    @(posedge sys_clk) disable iff (rst)
    route_res.remap_hit |-> $past(addr_hi) >= $past(s_q.low_bound) &&
      $past(addr_hi) <= $past(s_q.high_bound) && $past(win_on);
  endproperty
  a_hit_in_range: assert property (p_hit_in_range)
    else $error("remap hit outside window");

  property p_alias_match;
    @(posedge sys_clk) disable iff (rst)
    (host_cyc.valid && host_cyc.is_io && host_cyc.addr[9:0] == 10'h3b4 &&
     host_cyc.byte_en[0]) |=> route_res.legacy_hit;
  endproperty
  a_alias_match: assert property (p_alias_match)
    else $error("mono port alias not decoded");

  property p_mono_mem_south;
    @(posedge sys_clk) disable iff (rst)
    (host_cyc.valid && !host_cyc.is_io && host_cyc.addr[35:15] == 21'h16)
      |=> route_res.legacy_hit &&
      route_res.dest == legacy_route_pkg::DEST_SOUTH_LINK;
  endproperty
  a_mono_mem_south: assert property (p_mono_mem_south)
    else $error("mono memory range not decoded to south link");

  property p_low_read;
    @(posedge sys_clk) disable iff (rst)
    (cfg_req.rd && cfg_req.ofs == legacy_route_pkg::REMAP_LOW_OFS) |=>
      cfg_rvalid && cfg_rdata == {6'h00, $past(s_q.low_bound)};
  endproperty
  a_low_read: assert property (p_low_read)
    else $error("low bound read back wrong");

  property p_high_read;
    @(posedge sys_clk) disable iff (rst)
    (cfg_req.rd && cfg_req.ofs == legacy_route_pkg::REMAP_HIGH_OFS) |=>
      cfg_rvalid && cfg_rdata == {6'h00, $past(s_q.high_bound)};
  endproperty
  a_high_read: assert property (p_high_read)
    else $error("high bound read back wrong");

  property p_win_flag;
    @(posedge sys_clk) disable iff (rst)
    1'b1 |=> remap_win_enabled ==
      ($past(s_q.low_bound) <= $past(s_q.high_bound));
  endproperty
  a_win_flag: assert property (p_win_flag)
    else $error("window flag disagrees with bounds");

  c_remap_hit: cover property (@(posedge sys_clk) disable iff (rst)
    route_res.remap_hit);
  c_gfx_route: cover property (@(posedge sys_clk) disable iff (rst)
    route_res.valid && route_res.dest == legacy_route_pkg::DEST_GFX_PORT);
  c_mono_io: cover property (@(posedge sys_clk) disable iff (rst)
    host_cyc.valid && mono_io);
  c_window_open: cover property (@(posedge sys_clk) disable iff (rst)
    remap_win_enabled);

endmodule : legacy_route_remap_decode

// ---- host_bus_model.sv ----
// Host processor bus model: issues one memory or I/O cycle at a time.
// Assumes the decoder samples host_cyc on every rising sys_clk edge.
`timescale 1ns/1ps

module host_bus_model (
  input wire logic sys_clk,
  output legacy_route_pkg::host_cyc_t host_cyc
);
  // Quiet bus from time zero
  initial host_cyc = '0;

  // One-cycle request; released lanes show inverted values, never stale
  task automatic send(input logic io, input logic [35:0] a,
                      input logic [3:0] be);
    @(posedge sys_clk);
    host_cyc <= '{valid: 1'b1, is_io: io, addr: a, byte_en: be};
    @(posedge sys_clk);
    host_cyc <= '{valid: 1'b0, is_io: ~io, addr: ~a, byte_en: ~be};
  endtask : send
endmodule : host_bus_model

// ---- testbench.sv ----
// Self-checking bench for the legacy route and remap decoder.
// Assumes the package, the decoder and host_bus_model are compiled first.
`timescale 1ns/1ps

module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic vga_route_enable = 1'b0;
  logic mono_adapter_present = 1'b0;
  legacy_route_pkg::cfg_req_t cfg_req = '0;
  legacy_route_pkg::host_cyc_t host_cyc;
  legacy_route_pkg::route_res_t route_res;
  logic [15:0] cfg_rdata;
  logic cfg_rvalid;
  logic remap_win_enabled;
  int fail_count = 0;
  int checks = 0;

  // ---------------------------------------------------------------
  // Clock, partner and device
  // ---------------------------------------------------------------
  always #2.5 sys_clk = ~sys_clk;

  host_bus_model host (.sys_clk(sys_clk), .host_cyc(host_cyc));

  legacy_route_remap_decode uut (
    .sys_clk(sys_clk),
    .rst(rst),
    .vga_route_enable(vga_route_enable),
    .mono_adapter_present(mono_adapter_present),
    .cfg_req(cfg_req),
    .host_cyc(host_cyc),
    .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid),
    .route_res(route_res),
    .remap_win_enabled(remap_win_enabled)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cfg_wr(input logic [7:0] ofs, input logic [15:0] d);
    @(posedge sys_clk);
    cfg_req <= '{wr: 1'b1, rd: 1'b0, ofs: ofs, wdata: d};
    @(posedge sys_clk);
    cfg_req <= '0;
  endtask : cfg_wr

  // Read data is registered, so look one edge after the request
  task automatic cfg_rd(input logic [7:0] ofs, input logic [15:0] exp);
    @(posedge sys_clk);
    cfg_req <= '{wr: 1'b0, rd: 1'b1, ofs: ofs, wdata: 16'h0000};
    @(posedge sys_clk);
    cfg_req <= '0;
    #1;
    check("cfg_rvalid", 16'h0001, {15'h0000, cfg_rvalid});
    check("cfg_rdata", exp, cfg_rdata);
  endtask : cfg_rd

  // Bits: valid, legacy_hit, dest, remap_hit; dest ignored off legacy
  task automatic route(input logic io, input logic [35:0] a,
                       input logic [3:0] be, input logic [3:0] exp);
    logic [3:0] got;
    logic [3:0] want;
    host.send(io, a, be);
    #1;
    got = route_res;
    want = exp;
    if (exp[2] == 1'b0) begin
      got[1] = 1'b0;
      want[1] = 1'b0;
    end
    check("route_res", {12'h000, want}, {12'h000, got});
  endtask : route

  // Bound update shows on the window flag one edge after it is stored
  task automatic settle_window(input logic exp);
    repeat (3) @(posedge sys_clk);
    #1;
    check("remap_win_enabled", {15'h0000, exp}, {15'h0000, remap_win_enabled});
  endtask : settle_window

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic reset_values;
    settle_window(1'b0);
    cfg_rd(8'h98, 16'h03ff);
    cfg_rd(8'h9a, 16'h0000);
    cfg_rd(8'h9c, 16'h0000);
  endtask : reset_values

  // Only matched settings; mixed ones are left undefined
  task automatic legacy_modes;
    for (int m = 0; m < 2; m++) begin
      @(posedge sys_clk);
      vga_route_enable <= m[0];
      mono_adapter_present <= m[0];
      route(1'b0, 36'h0000b0000, 4'hf, 4'b1100);
      route(1'b0, 36'h0000b7fff, 4'hf, 4'b1100);
      route(1'b1, 36'h0000073b4, 4'h1, 4'b1100);
      route(1'b1, 36'h0000003b4, 4'hf, 4'b1100);
      route(1'b1, 36'h0000003bc, 4'hf, 4'b1100);
      route(1'b1, 36'h0000003b0, 4'h1, 4'b1000);
      route(1'b0, 36'h0000b8000, 4'hf, {2'b11, m[0], 1'b0});
      route(1'b1, 36'h0000003c0, 4'h1, {2'b11, m[0], 1'b0});
    end
  endtask : legacy_modes

  task automatic remap_window;
    cfg_wr(8'h98, 16'hfc04);
    cfg_wr(8'h9a, 16'h0008);
    settle_window(1'b1);
    cfg_rd(8'h98, 16'h0004);
    cfg_rd(8'h9a, 16'h0008);
    route(1'b0, {10'h004, 26'h0000000}, 4'hf, 4'b1001);
    route(1'b0, {10'h003, 26'h3ffffff}, 4'hf, 4'b1000);
    route(1'b0, {10'h008, 26'h3ffffff}, 4'hf, 4'b1001);
    route(1'b0, {10'h009, 26'h0000000}, 4'hf, 4'b1000);
    cfg_wr(8'h98, 16'h000a);
    settle_window(1'b0);
    route(1'b0, {10'h009, 26'h0000000}, 4'hf, 4'b1000);
    cfg_wr(8'h9a, 16'h000a);
    settle_window(1'b1);
    route(1'b0, {10'h00a, 26'h1234567}, 4'hf, 4'b1001);
  endtask : remap_window

  // ---------------------------------------------------------------
  // Verdict and main sequence
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    reset_values();
    legacy_modes();
    remap_window();
    // Second reset after bounds were moved
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    reset_values();
    final_report();
  end
endmodule : testbench
